/* File: rtl/event_task_link_regs.sv */
/*
 register slice of the event-to-task interconnect on an AXI4-Lite slave:
 channel 19 pointers and group 0/1 member masks.
 pointer writes outside their group window answer SLVERR and leave the word as it was.
 assumes one clock REF_CLK, async active-low RSTN, master obeying AXI4-Lite.
 assumes CE high to run; CE low freezes the handshake as well, so keep requests off then.
*/
// Behaviour
// - channel 19 event source pointer at 0x5A8, 32-bit RW, resets to zero
// - event pointer accepts only addresses inside the peripheral event group
// - channel 19 task target pointer at 0x5AC, 32-bit RW, resets to zero
// - task pointer accepts only addresses inside the peripheral task group
// - group 0 member mask at 0x800, RW, zero reset, bit n is channel n
// - group 1 member mask at 0x804, same layout as group 0
// - mask bit 0 excludes the channel, bit 1 includes it
`timescale 1ns/1ns
`default_nettype none
`include "event_task_link_consts.svh"
module event_task_link_regs #(
    parameter int          ADDR_W     = 12,
    parameter logic [31:0] EVENT_BASE = `EVENT_GROUP_BASE,
    parameter logic [31:0] EVENT_LIM  = `EVENT_GROUP_LIMIT,
    parameter logic [31:0] TASK_BASE  = `TASK_GROUP_BASE,
    parameter logic [31:0] TASK_LIM   = `TASK_GROUP_LIMIT
) (
    input  wire logic              REF_CLK,
    input  wire logic              RSTN,
    input  wire logic              CE,
    input  wire logic [ADDR_W-1:0] AWADDR,
    input  wire logic [2:0]        AWPROT,
    input  wire logic              AWVALID,
    output var  logic              AWREADY,
    input  wire logic [31:0]       WDATA,
    input  wire logic [3:0]        WSTRB,
    input  wire logic              WVALID,
    output var  logic              WREADY,
    output var  logic [1:0]        BRESP,
    output var  logic              BVALID,
    input  wire logic              BREADY,
    input  wire logic [ADDR_W-1:0] ARADDR,
    input  wire logic [2:0]        ARPROT,
    input  wire logic              ARVALID,
    output var  logic              ARREADY,
    output var  logic [31:0]       RDATA,
    output var  logic [1:0]        RRESP,
    output var  logic              RVALID,
    input  wire logic              RREADY,
    output var  logic [31:0]       EVENT_SOURCE_POINTER,
    output var  logic [31:0]       TASK_TARGET_POINTER,
    output var  logic [31:0]       GROUP0_MEMBER_MASK,
    output var  logic [31:0]       GROUP1_MEMBER_MASK
);
    typedef struct packed {
        event_task_link_pkg::wr_state_t wst;
        logic                           aw_have;
        logic [ADDR_W-1:0]              aw_addr;
        logic                           w_have;
        logic [31:0]                    w_data;
        logic [3:0]                     w_strb;
        logic                           awready;
        logic                           wready;
        logic                           bvalid;
        logic [1:0]                     bresp;
        event_task_link_pkg::rd_state_t rst;
        logic                           arready;
        logic                           rvalid;
        logic [31:0]                    rdata;
        logic [1:0]                     rresp;
    } bus_state_t;

    // every ready low in reset: nothing is taken before the first running edge
    localparam bus_state_t BUS_RESET = '{
        wst:     event_task_link_pkg::WR_IDLE,
        aw_have: 1'b0,
        aw_addr: '0,
        w_have:  1'b0,
        w_data:  '0,
        w_strb:  '0,
        awready: 1'b0,
        wready:  1'b0,
        bvalid:  1'b0,
        bresp:   `RESP_OKAY,
        rst:     event_task_link_pkg::RD_IDLE,
        arready: 1'b0,
        rvalid:  1'b0,
        rdata:   '0,
        rresp:   `RESP_OKAY
    };

    bus_state_t st_reg;
    bus_state_t st_next;

    logic [31:0] evt_q;
    logic [31:0] tsk_q;
    logic [31:0] g0_q;
    logic [31:0] g1_q;
    logic        wr_evt;
    logic        wr_tsk;
    logic        wr_g0;
    logic        wr_g1;
    logic        wr_fire;
    logic [ADDR_W-1:0] waddr_word;
    logic [ADDR_W-1:0] raddr_word;
    logic [31:0] wmerged_evt;
    logic [31:0] wmerged_tsk;
    logic        evt_ok;
    logic        tsk_ok;
    logic        hit_evt;
    logic        hit_tsk;
    logic        hit_g0;
    logic        hit_g1;
    logic        wr_taken;

    // partial strobes merge against the held value before range checking
    // same lane merge as the word itself, so the window test sees the final value
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    assign wr_fire     = st_reg.aw_have && st_reg.w_have
                         && st_reg.wst == event_task_link_pkg::WR_IDLE;
    // address bits [1:0] are ignored: every register is one whole word
    assign waddr_word  = {st_reg.aw_addr[ADDR_W-1:2], 2'b00};
    assign raddr_word  = {ARADDR[ADDR_W-1:2], 2'b00};
    assign wmerged_evt = merge(evt_q, st_reg.w_data, st_reg.w_strb);
    assign wmerged_tsk = merge(tsk_q, st_reg.w_data, st_reg.w_strb);
    // out-of-group pointers are dropped, old value kept, SLVERR returned
    assign evt_ok      = wmerged_evt >= EVENT_BASE && wmerged_evt <= EVENT_LIM;
    assign tsk_ok      = wmerged_tsk >= TASK_BASE && wmerged_tsk <= TASK_LIM;
    assign hit_evt     = waddr_word == `OFS_CH19_EVENT_SOURCE_POINTER;
    assign hit_tsk     = waddr_word == `OFS_CH19_TASK_TARGET_POINTER;
    assign hit_g0      = waddr_word == `OFS_GROUP0_MEMBER_MASK;
    assign hit_g1      = waddr_word == `OFS_GROUP1_MEMBER_MASK;
    assign wr_evt      = wr_fire && hit_evt && evt_ok;
    assign wr_tsk      = wr_fire && hit_tsk && tsk_ok;
    assign wr_g0       = wr_fire && hit_g0;
    assign wr_g1       = wr_fire && hit_g1;
    assign wr_taken    = wr_evt || wr_tsk || wr_g0 || wr_g1;

    always_comb begin
        st_next = st_reg;
        st_next.awready = 1'b0;
        st_next.wready  = 1'b0;
        st_next.arready = 1'b0;
        // write address and data captured independently, either order
        if (AWVALID && st_reg.awready) begin
            st_next.aw_have = 1'b1;
            st_next.aw_addr = AWADDR;
        end
        if (WVALID && st_reg.wready) begin
            st_next.w_have = 1'b1;
            st_next.w_data = WDATA;
            st_next.w_strb = WSTRB;
        end
        // response stands until BREADY; no new address or data is taken meanwhile
        case (st_reg.wst)
            event_task_link_pkg::WR_IDLE: begin
                if (wr_fire) begin
                    st_next.aw_have = 1'b0;
                    st_next.w_have  = 1'b0;
                    st_next.bvalid  = 1'b1;
                    st_next.wst     = event_task_link_pkg::WR_RESP;
                    if (wr_taken) begin
                        st_next.bresp = `RESP_OKAY;
                    end else begin
                        // unmapped offset, or a pointer outside its group window
                        st_next.bresp = `RESP_SLVERR;
                    end
                end else begin
                    st_next.awready = !st_next.aw_have && !(AWVALID && st_reg.awready);
                    st_next.wready  = !st_next.w_have && !(WVALID && st_reg.wready);
                end
            end
            event_task_link_pkg::WR_RESP: begin
                if (BREADY) begin
                    st_next.bvalid = 1'b0;
                    st_next.wst    = event_task_link_pkg::WR_IDLE;
                end
            end
            default: begin
                st_next.wst    = event_task_link_pkg::WR_IDLE;
                st_next.bvalid = 1'b0;
            end
        endcase
        // reads never disturb state; unmapped reads answer zero with SLVERR
        case (st_reg.rst)
            event_task_link_pkg::RD_IDLE: begin
                if (ARVALID && st_reg.arready) begin
                    st_next.rvalid = 1'b1;
                    st_next.rresp  = `RESP_OKAY;
                    st_next.rst    = event_task_link_pkg::RD_DATA;
                    case (raddr_word)
                        `OFS_CH19_EVENT_SOURCE_POINTER: st_next.rdata = evt_q;
                        `OFS_CH19_TASK_TARGET_POINTER:  st_next.rdata = tsk_q;
                        `OFS_GROUP0_MEMBER_MASK:        st_next.rdata = g0_q;
                        `OFS_GROUP1_MEMBER_MASK:        st_next.rdata = g1_q;
                        default: begin
                            st_next.rdata = 32'h00000000;
                            st_next.rresp = `RESP_SLVERR;
                        end
                    endcase
                end else begin
                    st_next.arready = 1'b1;
                end
            end
            event_task_link_pkg::RD_DATA: begin
                if (RREADY) begin
                    st_next.rvalid  = 1'b0;
                    st_next.rst     = event_task_link_pkg::RD_IDLE;
                end
            end
            default: begin
                st_next.rst    = event_task_link_pkg::RD_IDLE;
                st_next.rvalid = 1'b0;
            end
        endcase
    end

    // CE low freezes the whole slice, handshake included
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            st_reg <= BUS_RESET;
        end else if (CE) begin
            st_reg <= st_next;
        end
    end

    // one word per register; a refused pointer write never strobes its word
    reg_word #(
        .RESET_VALUE(`RST_POINTER)
    ) u_evt (
        .clk  (REF_CLK),
        .rst_n(RSTN),
        .ce   (CE),
        .wr   (wr_evt),
        .strb (st_reg.w_strb),
        .wdata(st_reg.w_data),
        .q    (evt_q)
    );

    reg_word #(
        .RESET_VALUE(`RST_POINTER)
    ) u_tsk (
        .clk  (REF_CLK),
        .rst_n(RSTN),
        .ce   (CE),
        .wr   (wr_tsk),
        .strb (st_reg.w_strb),
        .wdata(st_reg.w_data),
        .q    (tsk_q)
    );

    reg_word #(
        .RESET_VALUE(`RST_MEMBER_MASK)
    ) u_g0 (
        .clk  (REF_CLK),
        .rst_n(RSTN),
        .ce   (CE),
        .wr   (wr_g0),
        .strb (st_reg.w_strb),
        .wdata(st_reg.w_data),
        .q    (g0_q)
    );

    reg_word #(
        .RESET_VALUE(`RST_MEMBER_MASK)
    ) u_g1 (
        .clk  (REF_CLK),
        .rst_n(RSTN),
        .ce   (CE),
        .wr   (wr_g1),
        .strb (st_reg.w_strb),
        .wdata(st_reg.w_data),
        .q    (g1_q)
    );

    assign AWREADY = st_reg.awready;
    assign WREADY  = st_reg.wready;
    assign BVALID  = st_reg.bvalid;
    assign BRESP   = st_reg.bresp;
    assign ARREADY = st_reg.arready;
    assign RVALID  = st_reg.rvalid;
    assign RDATA   = st_reg.rdata;
    assign RRESP   = st_reg.rresp;
    // outputs come straight from register-word flip-flops
    assign EVENT_SOURCE_POINTER = evt_q;
    assign TASK_TARGET_POINTER  = tsk_q;
    assign GROUP0_MEMBER_MASK   = g0_q;
    assign GROUP1_MEMBER_MASK   = g1_q;

    // protection bits and address byte lanes are accepted and ignored
    logic unused_prot;
    assign unused_prot = ^{AWPROT, ARPROT, st_reg.aw_addr[1:0]};
endmodule // event_task_link_regs
`default_nettype wire

/* File: include/event_task_link_consts.svh */
/*
 constants of the event/task link register slice: offsets, reset values, bus codes.
 assumes byte addressing on a 32-bit AXI4-Lite register bus.
*/
`ifndef EVENT_TASK_LINK_CONSTS_SVH
`define EVENT_TASK_LINK_CONSTS_SVH

`define OFS_CH19_EVENT_SOURCE_POINTER 12'h5A8
`define OFS_CH19_TASK_TARGET_POINTER  12'h5AC
`define OFS_GROUP0_MEMBER_MASK        12'h800
`define OFS_GROUP1_MEMBER_MASK        12'h804
`define RST_POINTER                   32'h00000000
`define RST_MEMBER_MASK               32'h00000000
`define RESP_OKAY                     2'h0
`define RESP_SLVERR                   2'h2
`define EVENT_GROUP_BASE              32'h40000100
`define EVENT_GROUP_LIMIT             32'h400001FF
`define TASK_GROUP_BASE               32'h40000000
`define TASK_GROUP_LIMIT              32'h400000FF

`endif

/* File: include/event_task_link_pkg.sv */
/*
 types of the register slice's write and read handshake states; the storage word uses none.
 assumes nothing beyond a SystemVerilog compiler.
*/
package event_task_link_pkg;
    typedef enum logic [1:0] {
        WR_IDLE = 2'b00,
        WR_RESP = 2'b01
    } wr_state_t;
    typedef enum logic [1:0] {
        RD_IDLE = 2'b00,
        RD_DATA = 2'b01
    } rd_state_t;
endpackage

/* File: rtl/reg_word.sv */
/*
 one 32-bit register word with byte-lane write enables.
 assumes writes are qualified by the caller; value comes from a flip-flop.
*/
`timescale 1ns/1ns
`default_nettype none
module reg_word #(
    parameter logic [31:0] RESET_VALUE = 32'h00000000
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic        wr,
    input  wire logic [3:0]  strb,
    input  wire logic [31:0] wdata,
    output var  logic [31:0] q
);
    typedef struct packed {
        logic [31:0] word;
    } word_state_t;

    word_state_t st_reg;
    word_state_t st_next;

    always_comb begin
        st_next = st_reg;
        if (wr) begin
            for (int i = 0; i < 4; i++) begin
                if (strb[i]) begin
                    st_next.word[i*8 +: 8] = wdata[i*8 +: 8];
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '{word: RESET_VALUE};
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    assign q = st_reg.word;
endmodule // reg_word
`default_nettype wire

/* File: testbench/event_task_link_regs_props.sv */
/*
 checker for the event/task link register slice, bound onto its top module.
 assumes CE held high by the bench and aligned addresses.
*/
`timescale 1ns/1ns
`default_nettype none
`include "event_task_link_consts.svh"
module event_task_link_regs_props #(
    parameter logic [31:0] EVENT_BASE = 32'h00000000,
    parameter logic [31:0] EVENT_LIM  = 32'h00000000,
    parameter logic [31:0] TASK_BASE  = 32'h00000000,
    parameter logic [31:0] TASK_LIM   = 32'h00000000
) (
    input wire logic        REF_CLK,
    input wire logic        RSTN,
    input wire logic [11:0] ARADDR,
    input wire logic        ARVALID,
    input wire logic        ARREADY,
    input wire logic [1:0]  BRESP,
    input wire logic        BVALID,
    input wire logic        BREADY,
    input wire logic [31:0] RDATA,
    input wire logic        RVALID,
    input wire logic        RREADY,
    input wire logic [31:0] EVENT_SOURCE_POINTER,
    input wire logic [31:0] TASK_TARGET_POINTER,
    input wire logic [31:0] GROUP0_MEMBER_MASK,
    input wire logic [31:0] GROUP1_MEMBER_MASK
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RSTN);
    // zero is the reset value, so it stays legal
    chk_event_range:
    assert property (EVENT_SOURCE_POINTER == 32'h0 || (EVENT_SOURCE_POINTER >= EVENT_BASE
        && EVENT_SOURCE_POINTER <= EVENT_LIM)) else $error("event pointer out of range");
    chk_task_range:
    assert property (TASK_TARGET_POINTER == 32'h0 || (TASK_TARGET_POINTER >= TASK_BASE
        && TASK_TARGET_POINTER <= TASK_LIM)) else $error("task pointer out of range");
    chk_event_write:
    assert property ($changed(EVENT_SOURCE_POINTER) |-> $rose(BVALID) && BRESP == `RESP_OKAY)
        else $error("event pointer changed without accepted write");
    chk_task_write:
    assert property ($changed(TASK_TARGET_POINTER) |-> $rose(BVALID) && BRESP == `RESP_OKAY)
        else $error("task pointer changed without accepted write");
    chk_mask_write:
    assert property ($changed(GROUP0_MEMBER_MASK) || $changed(GROUP1_MEMBER_MASK)
        |-> $rose(BVALID)) else $error("member mask changed without write");
    chk_b_hold:
    assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
        else $error("write response dropped early");
    chk_r_hold:
    assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
        else $error("read data dropped early");
    chk_read_mask:
    assert property (ARVALID && ARREADY && ARADDR == `OFS_GROUP0_MEMBER_MASK
        |=> RVALID && RDATA == $past(GROUP0_MEMBER_MASK)) else $error("mask read wrong");
    chk_read_task:
    assert property (ARVALID && ARREADY && ARADDR == `OFS_CH19_TASK_TARGET_POINTER
        |=> RVALID && RDATA == $past(TASK_TARGET_POINTER)) else $error("task read wrong");
endmodule // event_task_link_regs_props
bind event_task_link_regs event_task_link_regs_props #(.EVENT_BASE(EVENT_BASE),
    .EVENT_LIM(EVENT_LIM), .TASK_BASE(TASK_BASE), .TASK_LIM(TASK_LIM)) props_i (
    .REF_CLK(REF_CLK), .RSTN(RSTN), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .RDATA(RDATA), .RVALID(RVALID),
    .RREADY(RREADY), .EVENT_SOURCE_POINTER(EVENT_SOURCE_POINTER),
    .TASK_TARGET_POINTER(TASK_TARGET_POINTER), .GROUP0_MEMBER_MASK(GROUP0_MEMBER_MASK),
    .GROUP1_MEMBER_MASK(GROUP1_MEMBER_MASK));
`default_nettype wire

/* File: testbench/tb_top.sv */
/*
 self-checking bench for the event/task link register slice.
 assumes the consts header on the include path; CE tied high.
*/
`timescale 1ns/1ns
`default_nettype none
`include "event_task_link_consts.svh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
    $display("unexpected %s exp %h got %h", n, e, g); end end
module tb_top;
    logic        REF_CLK = 1'b0;
    logic        RSTN, CE, AWVALID, WVALID, BREADY, ARVALID, RREADY;
    logic        AWREADY, WREADY, BVALID, ARREADY, RVALID;
    logic [11:0] AWADDR, ARADDR;
    logic [2:0]  AWPROT, ARPROT;
    logic [3:0]  WSTRB;
    logic [1:0]  BRESP, RRESP;
    logic [31:0] WDATA, RDATA, EVENT_SOURCE_POINTER, TASK_TARGET_POINTER;
    logic [31:0] GROUP0_MEMBER_MASK, GROUP1_MEMBER_MASK;
    logic [31:0] seed = 32'hBA5BF134;
    logic [31:0] mdl [4];
    logic [11:0] ofs [4] = '{`OFS_CH19_EVENT_SOURCE_POINTER, `OFS_CH19_TASK_TARGET_POINTER,
                             `OFS_GROUP0_MEMBER_MASK, `OFS_GROUP1_MEMBER_MASK};
    int          fail_count = 0;
    int          comparisons = 0;
    always #2 REF_CLK = ~REF_CLK;
    event_task_link_regs event_task_link_regs_i (.REF_CLK(REF_CLK), .RSTN(RSTN), .CE(CE),
        .AWADDR(AWADDR), .AWPROT(AWPROT), .AWVALID(AWVALID), .AWREADY(AWREADY),
        .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
        .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARPROT(ARPROT),
        .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
        .RVALID(RVALID), .RREADY(RREADY), .EVENT_SOURCE_POINTER(EVENT_SOURCE_POINTER),
        .TASK_TARGET_POINTER(TASK_TARGET_POINTER), .GROUP0_MEMBER_MASK(GROUP0_MEMBER_MASK),
        .GROUP1_MEMBER_MASK(GROUP1_MEMBER_MASK));
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [31:0] merge(input logic [31:0] o, n, input logic [3:0] s);
        for (int b = 0; b < 4; b++) if (s[b]) o[8*b+:8] = n[8*b+:8];
        return o;
    endfunction
    // masks take anything; pointers only their group's window
    function automatic logic legal(input int i, input logic [31:0] v);
        if (i == 0) return v >= `EVENT_GROUP_BASE && v <= `EVENT_GROUP_LIMIT;
        if (i == 1) return v >= `TASK_GROUP_BASE && v <= `TASK_GROUP_LIMIT;
        return 1'b1;
    endfunction
    function automatic logic [31:0] port(input int i);
        return i == 0 ? EVENT_SOURCE_POINTER : i == 1 ? TASK_TARGET_POINTER :
               i == 2 ? GROUP0_MEMBER_MASK : GROUP1_MEMBER_MASK;
    endfunction
    task end_sim;
        if (fail_count == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic limit(input int n);
        if (n >= 100) begin
            fail_count++;
            end_sim();
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [1:0] r);
        int   n = 0;
        logic aw = 1'b1;
        logic w = 1'b1;
        AWADDR <= a;
        WDATA <= d;
        WSTRB <= s;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        while ((aw || w) && n < 100) begin
            @(posedge REF_CLK);
            n++;
            if (aw && AWREADY === 1'b1) begin aw = 1'b0; AWVALID <= 1'b0; end
            if (w && WREADY === 1'b1) begin w = 1'b0; WVALID <= 1'b0; end
        end
        limit(n);
        repeat (rnd() % 3) @(posedge REF_CLK);
        BREADY <= 1'b1;
        n = 0;
        do begin @(posedge REF_CLK); n++; end while (BVALID !== 1'b1 && n < 100);
        r = BRESP;
        BREADY <= 1'b0;
        limit(n);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int n = 0;
        ARADDR <= a;
        ARVALID <= 1'b1;
        do begin @(posedge REF_CLK); n++; end while (ARREADY !== 1'b1 && n < 100);
        ARVALID <= 1'b0;
        limit(n);
        repeat (rnd() % 3) @(posedge REF_CLK);
        RREADY <= 1'b1;
        n = 0;
        do begin @(posedge REF_CLK); n++; end while (RVALID !== 1'b1 && n < 100);
        d = RDATA;
        r = RRESP;
        RREADY <= 1'b0;
        limit(n);
    endtask
    task automatic step(input int i, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] q;
        logic [1:0]  r;
        logic        ok;
        ok = legal(i, merge(mdl[i], d, s));
        if (ok) mdl[i] = merge(mdl[i], d, s);
        wr(ofs[i], d, s, r);
        `CHK("write resp", ok ? `RESP_OKAY : `RESP_SLVERR, r)
        rd(ofs[i], q, r);
        `CHK("readback", {`RESP_OKAY, mdl[i]}, {r, q})
        `CHK("port value", mdl[i], port(i))
    endtask
    initial begin
        logic [31:0] q, d, s;
        logic [1:0]  r;
        int          k;
        {RSTN, AWVALID, WVALID, BREADY, ARVALID, RREADY} = '0;
        {CE, AWPROT, ARPROT, AWADDR, ARADDR, WDATA, WSTRB} = {1'b1, 66'h0};
        mdl = '{default: 32'h0};
        repeat (2) @(posedge REF_CLK);
        RSTN <= 1'b1;
        @(posedge REF_CLK);
        `CHK("reset ports", 128'h0, {port(0), port(1), port(2), port(3)})
        for (k = 0; k < 4; k++) begin
            rd(ofs[k], q, r);
            `CHK("reset value", 32'h0, q)
        end
        wr(12'h5B0, 32'hFFFFFFFF, 4'hF, r);
        `CHK("unmapped write", `RESP_SLVERR, r)
        rd(12'h5B0, q, r);
        `CHK("unmapped read", {`RESP_SLVERR, 32'h0}, {r, q})
        // window edges, then lane-wise and single-channel mask edits
        step(0, `EVENT_GROUP_LIMIT, 4'hF);
        step(0, `EVENT_GROUP_LIMIT + 32'h1, 4'hF);
        step(0, `EVENT_GROUP_BASE - 32'h1, 4'hF);
        step(0, 32'h00000000, 4'h1);
        step(1, `TASK_GROUP_LIMIT + 32'h1, 4'hF);
        step(1, `TASK_GROUP_BASE, 4'hF);
        step(2, 32'hFFFFFFFF, 4'hF);
        step(2, 32'h00000000, 4'h4);
        step(3, 32'h00080000, 4'hF);
        for (k = 0; k < 80; k++) begin
            d = rnd();
            s = rnd();
            if (k % 4 < 2 && d[31]) d = (k % 4 == 0 ? `EVENT_GROUP_BASE : `TASK_GROUP_BASE)
                                        | {24'h0, d[7:0]};
            step(k % 4, d, s[4] ? 4'hF : s[3:0]);
        end
        end_sim();
    end
endmodule // tb_top
`default_nettype wire
